/* File: rtl/aad_adder.sv */
// 8-bit adder with carry in and the five arithmetic flags
// assumes operands are stable for the whole cycle; purely combinational
`timescale 1ns/1ns
module aad_adder (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic carry_in,
    output logic [7:0] sum,
    output aad_pkg::aad_flags_t flags
);
    import aad_pkg::*;

    wire logic [4:0] low_nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}
        + {4'h0, carry_in};
    wire logic [8:0] full = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};

    assign sum = full[7:0];
    assign flags.carry = full[8];
    assign flags.digit_carry_flag = low_nib[4];
    assign flags.zero = (full[7:0] == 8'h00);
    assign flags.neg = full[7];
    // signed overflow: like signs in, other sign out
    assign flags.ovf = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);

endmodule // aad_adder

/* File: rtl/aad_addr_resolve.sv */
// turns the 8-bit file field into a 12-bit data memory address
// assumes bank and index base are held steady by the core
`timescale 1ns/1ns
module aad_addr_resolve (
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic ext_en,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    output logic [11:0] eff_addr,
    output logic indexed
);
    import aad_pkg::*;

    wire logic low_half = (file_addr <= AAD_ACCESS_SPLIT);
    wire logic [11:0] index_sum = index_base + {4'h0, file_addr};
    wire logic [11:0] access_addr = low_half ?
        {AAD_ACCESS_LOW_BANK, file_addr} : {AAD_ACCESS_HIGH_BANK, file_addr};
    wire logic [11:0] bank_addr = {bank_select_register, file_addr};

    assign indexed = !access_sel && ext_en && low_half;
    assign eff_addr = indexed ? index_sum :
        (!access_sel ? access_addr : bank_addr);

endmodule // aad_addr_resolve

/* File: rtl/aad_core.sv */
// add/and execution datapath with apb register access and data memory
// assumes an apb master on clk; one instruction per write to the
// instruction register, executed in the following cycle
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module aad_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] accum_out,
    output aad_pkg::aad_flags_t flags_out,
    output logic busy
);
    import aad_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    aad_state_t state_q;
    aad_state_t state_d;
    logic busy_q;
    logic ext_en_q;
    logic [3:0] bank_q;
    logic [11:0] index_q;
    logic [7:0] accum_q;
    aad_flags_t flags_q;
    logic [17:0] instr_q;
    logic [11:0] mem_addr_q;
    logic [11:0] last_addr_q;
    logic last_indexed_q;
    logic [7:0] last_result_q;
    logic bad_op_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [7:0] mem [AAD_MEM_DEPTH];

    // ************************************************************
    // apb decode
    // ************************************************************
    wire logic acc_done = psel && penable && pready_q;
    wire logic wr_take = acc_done && pwrite;
    wire logic pready_d = psel && penable && !pready_q;
    wire logic hit_ctrl = (paddr == AAD_OFF_CTRL);
    wire logic hit_bank = (paddr == AAD_OFF_BANK);
    wire logic hit_index = (paddr == AAD_OFF_INDEX);
    wire logic hit_accum = (paddr == AAD_OFF_ACCUM);
    wire logic hit_status = (paddr == AAD_OFF_STATUS);
    wire logic hit_instr = (paddr == AAD_OFF_INSTR);
    wire logic hit_maddr = (paddr == AAD_OFF_MEM_ADDR);
    wire logic hit_mdata = (paddr == AAD_OFF_MEM_DATA);
    wire logic hit_last = (paddr == AAD_OFF_LAST);
    wire logic unmapped = !(hit_ctrl || hit_bank || hit_index || hit_accum
        || hit_status || hit_instr || hit_maddr || hit_mdata || hit_last);
    // last is read-only; a write to it answers with an error
    wire logic bad_access = unmapped || (hit_last && pwrite);

    // ************************************************************
    // instruction decode
    // ************************************************************
    wire logic [7:0] lit = instr_q[7:0];
    wire logic [7:0] opc_hi = instr_q[15:8];
    wire logic is_add_lit = (opc_hi == AAD_OPC_ADD_LIT);
    wire logic is_and_lit = (opc_hi == AAD_OPC_AND_LIT);
    wire logic is_add_file = (instr_q[15:10] == AAD_OPC_ADD_FILE);
    wire logic is_addc_file = (instr_q[15:10] == AAD_OPC_ADDC_FILE);
    wire logic is_file = is_add_file || is_addc_file;
    wire logic is_known = is_add_lit || is_and_lit || is_file;
    // the omit bits stand for an operand left off: default is 1
    wire logic dest_file = instr_q[9]
        || instr_q[AAD_INSTR_DEST_OMIT_BIT];
    wire logic access_sel = instr_q[8]
        || instr_q[AAD_INSTR_ACC_OMIT_BIT];
    wire logic executing = (state_q == AAD_ST_EXEC);

    // ************************************************************
    // datapath
    // ************************************************************
    logic [11:0] eff_addr;
    logic indexed;
    logic [7:0] sum;
    aad_flags_t add_flags;

    aad_addr_resolve u_resolve (
        .file_addr(lit),
        .access_sel(access_sel),
        .ext_en(ext_en_q),
        .bank_select_register(bank_q),
        .index_base(index_q),
        .eff_addr(eff_addr),
        .indexed(indexed)
    );

    wire logic [7:0] file_val = mem[eff_addr];
    wire logic [7:0] add_rhs = is_file ? file_val : lit;
    wire logic add_cin = is_addc_file && flags_q.carry;

    aad_adder u_adder (
        .op_a(accum_q),
        .op_b(add_rhs),
        .carry_in(add_cin),
        .sum(sum),
        .flags(add_flags)
    );

    wire logic [7:0] and_val = accum_q & lit;
    wire logic [7:0] result = is_and_lit ? and_val : sum;
    wire aad_flags_t and_flags = '{neg: and_val[7],
        ovf: flags_q.ovf,
        zero: (and_val == 8'h00),
        digit_carry_flag: flags_q.digit_carry_flag,
        carry: flags_q.carry};
    wire aad_flags_t new_flags = is_and_lit ? and_flags : add_flags;
    // literal ops always land in the accumulator
    wire logic to_accum = !is_file || !dest_file;
    wire logic exec_ok = executing && is_known;
    wire logic accum_wr = exec_ok && to_accum;
    wire logic mem_exec_wr = exec_ok && !to_accum;

    // ************************************************************
    // read mux
    // ************************************************************
    wire logic [7:0] mem_rd = mem[mem_addr_q];
    wire logic [31:0] rd_ctrl = {31'h0, ext_en_q};
    wire logic [31:0] rd_bank = {28'h0, bank_q};
    wire logic [31:0] rd_index = {20'h0, index_q};
    wire logic [31:0] rd_accum = {24'h0, accum_q};
    wire logic [31:0] rd_status = {23'h0, executing, 3'h0, flags_q};
    wire logic [31:0] rd_instr = {14'h0, instr_q};
    wire logic [31:0] rd_maddr = {20'h0, mem_addr_q};
    wire logic [31:0] rd_mdata = {24'h0, mem_rd};
    wire logic [31:0] rd_last = {bad_op_q, 7'h0, last_result_q, 3'h0,
        last_indexed_q, last_addr_q};
    wire logic [31:0] rd_val =
        hit_ctrl ? rd_ctrl :
        hit_bank ? rd_bank :
        hit_index ? rd_index :
        hit_accum ? rd_accum :
        hit_status ? rd_status :
        hit_instr ? rd_instr :
        hit_maddr ? rd_maddr :
        hit_mdata ? rd_mdata :
        hit_last ? rd_last : 32'h0;

    // ************************************************************
    // sequencing
    // ************************************************************
    wire logic start = wr_take && hit_instr && !executing;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            AAD_ST_IDLE: begin
                if (start) begin
                    state_d = AAD_ST_EXEC;
                end
            end
            AAD_ST_EXEC: begin
                // single execute cycle for every known opcode
                state_d = AAD_ST_IDLE;
            end
            default: begin
                state_d = AAD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= AAD_ST_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // busy gets its own flop so the pin is not a decode
            busy_q <= (state_d == AAD_ST_EXEC);
        end
    end

    // ************************************************************
    // apb answer
    // ************************************************************
    // one wait state keeps prdata and pready straight from flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pready_d && bad_access;
            if (pready_d) begin
                prdata_q <= pwrite ? 32'h0 : rd_val;
            end
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_en_q <= 1'b0;
            bank_q <= AAD_RST_BANK;
            index_q <= AAD_RST_INDEX;
            mem_addr_q <= 12'h000;
            instr_q <= AAD_RST_INSTR;
        end else if (wr_take) begin
            if (hit_ctrl) begin
                ext_en_q <= pwdata[AAD_CTRL_EXT_BIT];
            end
            if (hit_bank) begin
                bank_q <= pwdata[3:0];
            end
            if (hit_index) begin
                index_q <= pwdata[11:0];
            end
            if (hit_maddr) begin
                mem_addr_q <= pwdata[11:0];
            end
            if (start) begin
                instr_q <= pwdata[17:0];
            end
        end
    end

    // ************************************************************
    // accumulator and flags
    // ************************************************************
    // execution and apb never collide: the apb answer needs two cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accum_q <= AAD_RST_ACCUM;
            flags_q <= AAD_RST_FLAGS;
        end else begin
            if (accum_wr) begin
                accum_q <= result;
            end else if (wr_take && hit_accum) begin
                accum_q <= pwdata[7:0];
            end
            if (exec_ok) begin
                flags_q <= new_flags;
            end else if (wr_take && hit_status) begin
                flags_q <= pwdata[4:0];
            end
        end
    end

    // ************************************************************
    // trace of the last instruction
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_addr_q <= 12'h000;
            last_indexed_q <= 1'b0;
            last_result_q <= 8'h00;
            bad_op_q <= 1'b0;
        end else if (executing) begin
            bad_op_q <= !is_known;
            if (is_known) begin
                last_addr_q <= is_file ? eff_addr : 12'h000;
                last_indexed_q <= is_file && indexed;
                last_result_q <= result;
            end
        end
    end

    // ************************************************************
    // data memory
    // ************************************************************
    // no reset on the array; contents are undefined until written
    always_ff @(posedge clk) begin
        if (mem_exec_wr) begin
            mem[eff_addr] <= result;
        end else if (wr_take && hit_mdata) begin
            mem[mem_addr_q] <= pwdata[7:0];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign accum_out = accum_q;
    assign flags_out = flags_q;
    assign busy = busy_q;

endmodule // aad_core

/* File: rtl/aad_pkg.sv */
// constants, field positions and carrier types for the add/and datapath
// assumes a single 100 MHz core clock and an apb master with 32-bit data
package aad_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] AAD_OFF_CTRL = 8'h00;
    localparam logic [7:0] AAD_OFF_BANK = 8'h04;
    localparam logic [7:0] AAD_OFF_INDEX = 8'h08;
    localparam logic [7:0] AAD_OFF_ACCUM = 8'h0c;
    localparam logic [7:0] AAD_OFF_STATUS = 8'h10;
    localparam logic [7:0] AAD_OFF_INSTR = 8'h14;
    localparam logic [7:0] AAD_OFF_MEM_ADDR = 8'h18;
    localparam logic [7:0] AAD_OFF_MEM_DATA = 8'h1c;
    localparam logic [7:0] AAD_OFF_LAST = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AAD_CTRL_EXT_BIT = 0;
    localparam int AAD_STATUS_BUSY_BIT = 8;
    localparam int AAD_INSTR_DEST_OMIT_BIT = 16;
    localparam int AAD_INSTR_ACC_OMIT_BIT = 17;
    localparam int AAD_LAST_INDEXED_BIT = 12;
    localparam int AAD_LAST_RESULT_LSB = 16;
    localparam int AAD_LAST_BAD_OP_BIT = 31;

    // ************************************************************
    // opcode fields and addressing constants
    // ************************************************************
    localparam logic [7:0] AAD_OPC_ADD_LIT = 8'h0f;
    localparam logic [7:0] AAD_OPC_AND_LIT = 8'h0b;
    localparam logic [5:0] AAD_OPC_ADD_FILE = 6'h09;
    localparam logic [5:0] AAD_OPC_ADDC_FILE = 6'h08;
    localparam logic [7:0] AAD_ACCESS_SPLIT = 8'h5f;
    localparam logic [3:0] AAD_ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] AAD_ACCESS_HIGH_BANK = 4'hf;
    localparam int AAD_MEM_DEPTH = 4096;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] AAD_RST_ACCUM = 8'h00;
    localparam logic [3:0] AAD_RST_BANK = 4'h0;
    localparam logic [11:0] AAD_RST_INDEX = 12'h000;
    localparam logic [17:0] AAD_RST_INSTR = 18'h00000;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } aad_flags_t;

    localparam aad_flags_t AAD_RST_FLAGS = 5'h00;

    typedef enum logic [1:0] {
        AAD_ST_IDLE = 2'b01,
        AAD_ST_EXEC = 2'b10
    } aad_state_t;

endpackage

/* File: tb/aad_core_checker.sv */
// port-level assertions for the add/and datapath
// assumes binding onto aad_core; one clock, async active-low reset
`timescale 1ns/1ns
module aad_core_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] accum_out,
    input wire aad_pkg::aad_flags_t flags_out,
    input wire logic busy
);
    import aad_pkg::*;
    // ************************************************************
    // instruction decode as seen on the bus
    // ************************************************************
    logic go, add_k, and_k, file_op, to_acc;
    assign go = psel && penable && pready && pwrite && paddr == AAD_OFF_INSTR;
    assign add_k = go && pwdata[15:8] == AAD_OPC_ADD_LIT;
    assign and_k = go && pwdata[15:8] == AAD_OPC_AND_LIT;
    assign file_op = go && pwdata[15:11] == 5'h04;
    assign to_acc = !pwdata[9] && !pwdata[16];
    // results land one edge after the accepting edge; the checks sample them at the second
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    busy_pulse_a: assert property (
        go |=> busy ##1 !busy) else $error("busy not a one-cycle pulse");
    busy_cause_a: assert property (
        $rose(busy) |-> $past(go)) else $error("busy without instruction");
    add_sum_a: assert property (
        add_k |=> ##1 {flags_out.carry, accum_out} ==
            {1'b0, $past(accum_out, 2)} + {1'b0, $past(pwdata[7:0], 2)})
        else $error("add literal sum or carry wrong");
    add_zn_a: assert property (
        add_k |=> ##1 flags_out.zero == (accum_out == 8'h00)
            && flags_out.neg == accum_out[7]) else $error("add zero/neg");
    and_res_a: assert property (
        and_k |=> ##1 accum_out == ($past(accum_out, 2)
            & $past(pwdata[7:0], 2))) else $error("and literal result");
    and_keep_a: assert property (
        and_k |=> ##1 flags_out.carry == $past(flags_out.carry, 2)
            && flags_out.ovf == $past(flags_out.ovf, 2)
            && flags_out.digit_carry_flag ==
            $past(flags_out.digit_carry_flag, 2))
        else $error("and literal touched arithmetic flags");
    file_keep_a: assert property (
        file_op && !to_acc |=> ##1 accum_out == $past(accum_out, 2))
        else $error("file destination changed accumulator");
    file_zn_a: assert property (
        file_op && to_acc |=> ##1 flags_out.zero == (accum_out == 8'h00)
            && flags_out.neg == accum_out[7]) else $error("file zero/neg");
endmodule // aad_core_checker

bind aad_core aad_core_checker chk_u (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .paddr(paddr),
    .pwdata(pwdata),
    .accum_out(accum_out),
    .flags_out(flags_out),
    .busy(busy)
);

/* File: tb/aad_core_tb.sv */
// self-checking bench for the add/and datapath over apb
// assumes aad_core with the register map of aad_pkg
`timescale 1ns/1ns
module aad_core_tb;
    import aad_pkg::*;
    typedef struct {string nm; logic [32:0] v;} aad_exp_t;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0] paddr, accum_out, acc, mem, f, k, res;
    logic [31:0] pwdata, prdata;
    aad_flags_t flags_out;
    aad_exp_t exp_q[$];
    aad_exp_t mon_e;
    int bad_count, n_tests, seed;
    logic [4:0] st, nf;
    logic [11:0] ea, idx;
    logic [3:0] bk;
    logic ext, d, a, od, oa, ix, cin, opc;

    aad_core dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .accum_out(accum_out),
        .flags_out(flags_out), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // bus master and response monitor
    // ************************************************************
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            mon_e = (exp_q.size() == 0) ? '{"stray", 33'h0}
                : exp_q.pop_front();
            n_tests++;
            if ({pslverr, prdata} !== mon_e.v) begin
                bad_count++;
                $display("ERROR %s expected %h seen %h", mon_e.nm, mon_e.v,
                    {pslverr, prdata});
            end
        end
    end

    // idle cycle first, so no signal is driven twice in one step
    task automatic xfer(input logic wr, input logic [7:0] ad,
            input logic [31:0] dt, input logic [32:0] ev, input string nm);
        int i;
        @(posedge clk);
        exp_q.push_back('{nm, ev});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= dt;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("ERROR pready expected 1 seen %b", pready);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        xfer(1'b1, ad, dt, 33'h0, "write");
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] ev,
            input string nm);
        xfer(1'b0, ad, 32'h0, {1'b0, ev}, nm);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // returns {neg, ovf, zero, digit carry, carry, sum}
    function automatic logic [12:0] add_m(logic [7:0] x, y, logic c);
        logic [8:0] r;
        logic h;
        r = x + y + c;
        h = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + c) > 5'h0f;
        return {r[7], x[7] == y[7] && r[7] != x[7], r[7:0] == 8'h00, h,
            r[8], r[7:0]};
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        seed = 32'h5ab0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++)
            if (i != 7) rd(8'(i * 4), 32'h0, "reset_value");
        xfer(1'b0, 8'h24, 32'h0, {1'b1, 32'h0}, "unmapped");
        xfer(1'b1, AAD_OFF_LAST, 32'h1, {1'b1, 32'h0}, "last_write");
        $display("reset and map test done");
        repeat (16) begin
            acc = 8'($random(seed));
            k = 8'($random(seed));
            st = 5'($random(seed));
            opc = 1'($random(seed));
            wr(AAD_OFF_ACCUM, {24'h0, acc});
            wr(AAD_OFF_STATUS, {27'h0, st});
            wr(AAD_OFF_INSTR,
                {16'h0, opc ? AAD_OPC_ADD_LIT : AAD_OPC_AND_LIT, k});
            {nf, res} = add_m(acc, k, 1'b0);
            if (!opc) begin
                res = acc & k;
                nf = {res[7], st[3], res == 8'h00, st[1:0]};
            end
            rd(AAD_OFF_ACCUM, {24'h0, res}, "accum");
            rd(AAD_OFF_STATUS, {27'h0, nf}, "status");
            rd(AAD_OFF_LAST, {8'h0, res, 16'h0}, "last");
        end
        $display("literal test done");
        // unknown opcode: only the trace flag moves
        wr(AAD_OFF_INSTR, 32'h0);
        rd(AAD_OFF_ACCUM, {24'h0, res}, "accum_keep");
        rd(AAD_OFF_STATUS, {27'h0, nf}, "status_keep");
        rd(AAD_OFF_LAST, {1'b1, 7'h0, res, 16'h0}, "last_bad_op");
        $display("unknown opcode test done");
        for (int i = 0; i < 40; i++) begin
            acc = 8'($random(seed));
            mem = 8'($random(seed));
            st = 5'($random(seed));
            bk = 4'($random(seed));
            idx = 12'($random(seed));
            {ext, d, a, od, oa, opc} = 6'($random(seed));
            // boundary of the indexed window on half the passes
            f = i[1] ? 8'($random(seed)) : (i[0] ? 8'h60 : 8'h5f);
            cin = opc ? 1'b0 : st[0];
            ix = !(a | oa) && ext && f <= AAD_ACCESS_SPLIT;
            ea = (a | oa) ? {bk, f} : ix ? idx + 12'(f) :
                {(f > AAD_ACCESS_SPLIT) ? AAD_ACCESS_HIGH_BANK
                : AAD_ACCESS_LOW_BANK, f};
            wr(AAD_OFF_CTRL, {31'h0, ext});
            wr(AAD_OFF_BANK, {28'h0, bk});
            wr(AAD_OFF_INDEX, {20'h0, idx});
            wr(AAD_OFF_MEM_ADDR, {20'h0, ea});
            wr(AAD_OFF_MEM_DATA, {24'h0, mem});
            wr(AAD_OFF_ACCUM, {24'h0, acc});
            wr(AAD_OFF_STATUS, {27'h0, st});
            wr(AAD_OFF_INSTR, {14'h0, oa, od,
                opc ? AAD_OPC_ADD_FILE : AAD_OPC_ADDC_FILE, d, a, f});
            {nf, res} = add_m(acc, mem, cin);
            rd(AAD_OFF_ACCUM, 32'(d | od ? acc : res), "accum");
            rd(AAD_OFF_MEM_DATA, 32'(d | od ? res : mem), "mem");
            rd(AAD_OFF_STATUS, {27'h0, nf}, "status");
            rd(AAD_OFF_LAST, {8'h0, res, 3'h0, ix, ea}, "last");
        end
        $display("file operand test done");
        // second reset in mid-run must clear everything but the memory
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(AAD_OFF_CTRL, 32'h0, "ctrl_rst");
        rd(AAD_OFF_ACCUM, 32'h0, "accum_rst");
        rd(AAD_OFF_STATUS, 32'h0, "status_rst");
        rd(AAD_OFF_LAST, 32'h0, "last_rst");
        $display("mid-run reset test done");
        complete_run();
    end
endmodule // aad_core_tb
